/* hdl/emb_pkg.sv */
// Package with constants and types of the external memory bus port
package emb_pkg;
  localparam int unsigned ADDR_W       = 16;   // Address bus width
  localparam int unsigned DATA_W       = 16;   // Data bus width
  localparam int unsigned PORT_W       = 8;    // Width of one alternate port
  localparam int unsigned STROBE_CYC   = 2;    // Cycles a strobe stays low
  localparam logic [1:0]  STROBE_LAST  = 2'h1; // Last strobe count value
  localparam logic [7:0]  ALT_SEL_RST  = 8'h00; // Pins owned by address bus
  localparam logic [7:0]  ALT_DIR_RST  = 8'h00; // Alternate pins are inputs
  localparam logic [15:0] DATA_RST     = 16'h0000; // Data reset value
  localparam logic [15:0] ADDR_RST     = 16'h0000; // Address reset value

  // Bus cycle states
  typedef enum logic [1:0] {
    EMB_IDLE,
    EMB_READ,
    EMB_WRITE,
    EMB_DONE
  } emb_state_e;
endpackage : emb_pkg

/* hdl/emb_pin_mux.sv */
// Pin mux for one eight-bit group of shared address pins
`timescale 1ns/1ns
module emb_pin_mux #(
  parameter int unsigned WIDTH = 8              // Pins in the group
) (
  input  wire logic             mclk_i,         // Core clock
  input  wire logic             srst_i,         // Synchronous reset
  input  wire logic [WIDTH-1:0] addr_i,         // Address byte
  input  wire logic [WIDTH-1:0] alt_sel_i,      // 1 selects port use
  input  wire logic [WIDTH-1:0] alt_dir_i,      // 1 means output
  input  wire logic [WIDTH-1:0] alt_out_i,      // Port output values
  input  wire logic [WIDTH-1:0] pin_in_i,       // Pin levels
  output logic      [WIDTH-1:0] pin_o,          // Pin drive value
  output logic      [WIDTH-1:0] pin_oe_o,       // Pin drive enable
  output logic      [WIDTH-1:0] alt_in_o        // Synchronised pin levels
);
  import emb_pkg::*;

  logic [WIDTH-1:0] sync1_q;                    // First sync stage
  logic [WIDTH-1:0] sync2_q;                    // Second sync stage

  // Per pin: address or port function
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          pin_o[g]    <= 1'b0;
          pin_oe_o[g] <= 1'b1;                  // Address use after reset
        end else if (!alt_sel_i[g]) begin
          pin_o[g]    <= addr_i[g];             // Address drive
          pin_oe_o[g] <= 1'b1;
        end else begin
          pin_o[g]    <= alt_out_i[g];          // Port use, own direction
          pin_oe_o[g] <= alt_dir_i[g];
        end
      end
    end
  endgenerate

  // Three-stage synchroniser of pin levels (sync1_q, sync2_q, then alt_in_o)
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      alt_in_o <= '0;
    end else begin
      sync1_q  <= pin_in_i;
      sync2_q  <= sync1_q;
      alt_in_o <= sync2_q;
    end
  end
endmodule : emb_pin_mux

/* hdl/emb_port.sv */
// External memory bus port: address, data, selects, strobes
// Behaviour
// - Low address byte driven on accesses
// - High address byte driven on accesses
// - Address pins usable as two ports
// - Address function selected after reset
// - Data bus floats when bus idle
// - Program select low for program accesses
// - Data select low for data accesses
// - Read strobe low, data sampled one cycle before its rise
// - Write strobe low, data driven out
`timescale 1ns/1ns
module emb_port (
  input  wire logic                      mclk_i,       // 10 MHz core clock
  input  wire logic                      srst_i,       // Synchronous reset
  // Request side, from the core
  input  wire logic                      req_i,        // Access request pulse
  input  wire logic                      req_write_i,  // 1 write, 0 read
  input  wire logic                      req_prog_i,   // 1 program space
  input  wire logic [emb_pkg::ADDR_W-1:0] req_addr_i,  // Word address
  input  wire logic [emb_pkg::DATA_W-1:0] req_wdata_i, // Write data
  output logic                           busy_o,       // Access in progress
  output logic                           done_o,       // Access end pulse
  output logic      [emb_pkg::DATA_W-1:0] rdata_o,     // Read data
  // Alternate port control and port input levels
  input  wire logic [emb_pkg::ADDR_W-1:0] alt_sel_i,   // 1 = port use
  input  wire logic [emb_pkg::ADDR_W-1:0] alt_dir_i,   // 1 = output
  input  wire logic [emb_pkg::ADDR_W-1:0] alt_out_i,   // Port out values
  output logic      [emb_pkg::PORT_W-1:0] low_addr_alt_port_o,  // Port in
  output logic      [emb_pkg::PORT_W-1:0] high_addr_alt_port_o, // Port in
  // Shared address pins
  input  wire logic [emb_pkg::ADDR_W-1:0] ext_addr_bus_i,  // Pin levels
  output logic      [emb_pkg::ADDR_W-1:0] ext_addr_bus_o,  // Pin drive
  output logic      [emb_pkg::ADDR_W-1:0] ext_addr_bus_oe_o, // Enables
  // Data pins and bus control pins
  input  wire logic [emb_pkg::DATA_W-1:0] ext_data_bus_i,  // Data pins
  output logic      [emb_pkg::DATA_W-1:0] ext_data_bus_o,  // Data drive
  output logic                           ext_data_bus_oe_o, // Data enable
  output logic                           program_space_select_n_o, // Select
  output logic                           data_space_select_n_o,    // Select
  output logic                           read_strobe_n_o,  // Read strobe
  output logic                           write_strobe_n_o  // Write strobe
);
  import emb_pkg::*;

  // Bus cycle bookkeeping
  emb_state_e        state_q;            // Bus cycle state
  logic [1:0]        cnt_q;              // Strobe low counter
  logic              rd_was_q;           // Last access was a read
  // Address path
  logic [ADDR_W-1:0] addr_q;             // Address of current access
  logic [ADDR_W-1:0] addr_d;             // Address the pins take next
  // Data input path
  logic [DATA_W-1:0] dsync1_q;           // Data pin sync first stage
  logic [DATA_W-1:0] dsync2_q;           // Data pin sync second stage
  // Decoded events
  logic              take_w;             // Request accepted this cycle
  logic              strobe_end_w;       // Last cycle of strobe low

  // True while a strobe is low, in either direction. Shared by the
  // sequencer decode and the busy flag so both agree on the window.
  function automatic logic in_strobe(input emb_state_e st);
    return (st == EMB_READ) || (st == EMB_WRITE);
  endfunction

  // Request decode: only an idle port accepts a request; a request that
  // arrives mid-access is dropped without any indication, so the core
  // must wait for busy to fall before it asks again.
  always_comb begin
    take_w       = (state_q == EMB_IDLE) && req_i;
    strobe_end_w = in_strobe(state_q) && (cnt_q == STROBE_LAST);
  end

  // Next address for the pin groups. The pins load it on the same edge
  // that pulls the strobe low, so the address already stands when the
  // memory is first enabled and a stale address is never qualified.
  // Between accesses the pins keep the last address.
  always_comb begin
    addr_d = take_w ? req_addr_i : addr_q;
  end

  // Access sequencing: idle, strobe low for two cycles, one done cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      // Reset leaves the bus idle with the counter cleared
      state_q <= EMB_IDLE;
      cnt_q   <= 2'h0;
    end else begin
      case (state_q)
        EMB_IDLE: begin
          // Counter rests at zero so every access gets a full strobe
          cnt_q <= 2'h0;
          if (take_w) begin
            // Direction is fixed for the whole access here
            state_q <= req_write_i ? EMB_WRITE : EMB_READ;
          end
        end
        EMB_READ, EMB_WRITE: begin
          // Count strobe-low cycles; leave on the last one
          cnt_q <= cnt_q + 2'h1;
          if (strobe_end_w) begin
            state_q <= EMB_DONE;
          end
        end
        EMB_DONE: begin
          // Turnaround cycle: the done pulse goes out from here
          state_q <= EMB_IDLE;
        end
        default: begin
          // Unused encoding: recover to idle
          state_q <= EMB_IDLE;
        end
      endcase
    end
  end

  // Address, selects, strobes and write data. Selects and strobes change
  // together on one edge, so a select never stands without its strobe
  // and the memory sees one clean window per access.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      // Bus idle: selects and strobes high, data pins released
      addr_q                   <= ADDR_RST;
      program_space_select_n_o <= 1'b1;          // Idle high
      data_space_select_n_o    <= 1'b1;
      read_strobe_n_o          <= 1'b1;
      write_strobe_n_o         <= 1'b1;
      ext_data_bus_o           <= DATA_RST;
      ext_data_bus_oe_o        <= 1'b0;          // Float after reset
    end else if (take_w) begin
      // Start of access: one select, one strobe, write data if any.
      // Write data is launched with the strobe and held to its rise.
      addr_q                   <= req_addr_i;
      program_space_select_n_o <= !req_prog_i;   // Program access
      data_space_select_n_o    <= req_prog_i;    // Data access
      read_strobe_n_o          <= req_write_i;   // Read strobe
      write_strobe_n_o         <= !req_write_i;  // Write strobe
      ext_data_bus_o           <= req_wdata_i;
      ext_data_bus_oe_o        <= req_write_i;   // Drive on write
    end else if (strobe_end_w) begin
      // End of access: strobe rise is the memory's latch point for writes
      program_space_select_n_o <= 1'b1;          // Back to idle
      data_space_select_n_o    <= 1'b1;
      read_strobe_n_o          <= 1'b1;          // Rising edge ends read
      write_strobe_n_o         <= 1'b1;          // Memory latches here
      ext_data_bus_oe_o        <= 1'b0;          // Release data bus
    end
  end

  // Data pin synchroniser. The memory answers asynchronously, so its
  // word passes two flops before any logic looks at it; only the
  // second stage is read.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      // Both stages start cleared
      dsync1_q <= DATA_RST;
      dsync2_q <= DATA_RST;
    end else begin
      // Sample the pins every cycle, driven or not
      dsync1_q <= ext_data_bus_i;
      dsync2_q <= dsync1_q;
    end
  end

  // Read capture and status outputs. The word is taken from the
  // synchroniser output in the done cycle; it was sampled from the pins
  // while the read strobe was still low, so the memory must keep it
  // valid for the whole strobe window.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      // Nothing in flight, no stale data
      rdata_o <= DATA_RST;
      done_o  <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      busy_o <= take_w || in_strobe(state_q);    // Access in progress
      done_o <= (state_q == EMB_DONE);           // One-cycle end pulse
      if (state_q == EMB_DONE && rd_was_q) begin
        rdata_o <= dsync2_q;                     // Captured data
      end
    end
  end

  // Direction of the access in flight; writes leave read data alone
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_was_q <= 1'b0;
    end else if (take_w) begin
      rd_was_q <= !req_write_i;
    end
  end

  // Low address byte group. Each pin is either an address line or a
  // port line of its own direction; the group registers its drive, so
  // it is fed the next address to line up with the strobe edge.
  emb_pin_mux #(.WIDTH(PORT_W)) u_low (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .addr_i    (addr_d[PORT_W-1:0]),
    .alt_sel_i (alt_sel_i[PORT_W-1:0]),
    .alt_dir_i (alt_dir_i[PORT_W-1:0]),
    .alt_out_i (alt_out_i[PORT_W-1:0]),
    .pin_in_i  (ext_addr_bus_i[PORT_W-1:0]),
    .pin_o     (ext_addr_bus_o[PORT_W-1:0]),
    .pin_oe_o  (ext_addr_bus_oe_o[PORT_W-1:0]),
    .alt_in_o  (low_addr_alt_port_o)
  );

  // High address byte group, same structure as the low group; port
  // input levels come back through its own synchroniser.
  emb_pin_mux #(.WIDTH(PORT_W)) u_high (
    .mclk_i    (mclk_i),
    .srst_i    (srst_i),
    .addr_i    (addr_d[ADDR_W-1:PORT_W]),
    .alt_sel_i (alt_sel_i[ADDR_W-1:PORT_W]),
    .alt_dir_i (alt_dir_i[ADDR_W-1:PORT_W]),
    .alt_out_i (alt_out_i[ADDR_W-1:PORT_W]),
    .pin_in_i  (ext_addr_bus_i[ADDR_W-1:PORT_W]),
    .pin_o     (ext_addr_bus_o[ADDR_W-1:PORT_W]),
    .pin_oe_o  (ext_addr_bus_oe_o[ADDR_W-1:PORT_W]),
    .alt_in_o  (high_addr_alt_port_o)
  );
endmodule : emb_port

/* tb/emb_port_assertions.sv */
// Checker for the external memory bus port
`timescale 1ns/1ns
module emb_port_chk (
  input wire logic        mclk_i, srst_i, req_i, req_write_i, req_prog_i,
  input wire logic        busy_o, done_o, ext_data_bus_oe_o,
  input wire logic        program_space_select_n_o, data_space_select_n_o,
  input wire logic        read_strobe_n_o, write_strobe_n_o,
  input wire logic [15:0] req_addr_i, alt_sel_i, alt_dir_i,
  input wire logic [15:0] ext_addr_bus_o, ext_addr_bus_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic ps_n, ds_n, go;
  assign ps_n = program_space_select_n_o;
  assign ds_n = data_space_select_n_o;
  assign go   = req_i && !busy_o && !done_o;  // Request taken
  // Low for two cycles, then back high
  sequence s_low2(x);
    (!x)[*2] ##1 x;
  endsequence
  property p_prog; go && req_prog_i |=> s_low2(ps_n); endproperty
  property p_data; go && !req_prog_i |=> s_low2(ds_n); endproperty
  property p_rd;
    go && !req_write_i |=> s_low2(read_strobe_n_o) ##1 done_o;
  endproperty
  property p_wr;
    go && req_write_i |=> (!write_strobe_n_o && ext_data_bus_oe_o)[*2]
      ##1 !ext_data_bus_oe_o;
  endproperty
  property p_float; ext_data_bus_oe_o |-> !write_strobe_n_o; endproperty
  property p_one; ps_n || ds_n; endproperty
  property p_idle;
    !busy_o |-> ps_n && ds_n && read_strobe_n_o && write_strobe_n_o;
  endproperty
  property p_lo;
    go |=> ext_addr_bus_o[7:0] == $past(req_addr_i[7:0]);
  endproperty
  property p_hi;
    go |=> ext_addr_bus_o[15:8] == $past(req_addr_i[15:8]);
  endproperty
  property p_port;
    1 |=> ext_addr_bus_oe_o == (~$past(alt_sel_i) | $past(alt_dir_i));
  endproperty
  property p_rst; $fell(srst_i) |-> ext_addr_bus_oe_o == 16'hffff; endproperty
  a_prog: assert property (p_prog) else $error("program select");
  a_data: assert property (p_data) else $error("data select");
  a_rd: assert property (p_rd) else $error("read strobe");
  a_wr: assert property (p_wr) else $error("write strobe");
  a_float: assert property (p_float) else $error("data drive");
  a_one: assert property (p_one) else $error("two selects");
  a_idle: assert property (p_idle) else $error("idle levels");
  a_lo: assert property (p_lo) else $error("low address");
  a_hi: assert property (p_hi) else $error("high address");
  a_port: assert property (p_port) else $error("pin enable");
  a_rst: assert property (p_rst) else $error("reset pins");
endmodule // emb_port_chk
bind emb_port emb_port_chk u_chk (
  .mclk_i                   (mclk_i),
  .srst_i                   (srst_i),
  .req_i                    (req_i),
  .req_write_i              (req_write_i),
  .req_prog_i               (req_prog_i),
  .busy_o                   (busy_o),
  .done_o                   (done_o),
  .ext_data_bus_oe_o        (ext_data_bus_oe_o),
  .program_space_select_n_o (program_space_select_n_o),
  .data_space_select_n_o    (data_space_select_n_o),
  .read_strobe_n_o          (read_strobe_n_o),
  .write_strobe_n_o         (write_strobe_n_o),
  .req_addr_i               (req_addr_i),
  .alt_sel_i                (alt_sel_i),
  .alt_dir_i                (alt_dir_i),
  .ext_addr_bus_o           (ext_addr_bus_o),
  .ext_addr_bus_oe_o        (ext_addr_bus_oe_o)
);

/* tb/emb_sram.sv */
// Static memory model on the far side of the bus port
`timescale 1ns/1ns
module emb_sram #(parameter int HOLD = 3) (
  input  wire logic        mclk_i, ps_n_i, rd_n_i, wr_n_i,
  input  wire logic [15:0] addr_i, data_i,
  output logic      [15:0] data_o,
  output logic             drive_o
);
  logic [15:0] mem [logic [16:0]];   // Sparse storage
  logic [15:0] rd_q, wd_q = '0;      // Held read word, pending write
  logic [16:0] wk_q = '0;            // Pending write location
  int          hold_q = 0;           // Hold cycles left after read
  // Track strobes; keep read data briefly after the strobe rises
  always @(posedge mclk_i) begin
    if (!wr_n_i) {wk_q, wd_q} <= {ps_n_i, addr_i, data_i};
    if (!rd_n_i) begin
      rd_q   <= data_o;
      hold_q <= HOLD;
    end else if (hold_q > 0) hold_q <= hold_q - 1;
  end
  // Word latched as the write strobe returns high
  always @(posedge wr_n_i) mem[wk_q] = wd_q;
  // Drive while the read strobe is low, then hold
  always @* data_o = !rd_n_i ? (mem.exists({ps_n_i, addr_i}) ?
    mem[{ps_n_i, addr_i}] : 16'h0) : rd_q;
  assign drive_o = !rd_n_i || hold_q > 0;
endmodule // emb_sram

/* tb/tb_top.sv */
// Self-checking bench for the external memory bus port
`timescale 1ns/1ns
module tb_top;
  logic mclk_i = 0, srst_i = 1, req_i = 0, req_write_i = 0, req_prog_i = 0;
  logic [15:0] req_addr_i = '0, req_wdata_i = '0, alt_sel_i = '0, pad = '0;
  logic [15:0] alt_dir_i = '0, alt_out_i = '0, abus, dbus, ao, aoe, dout;
  logic [15:0] rdata_o, mdat;
  logic        busy_o, done_o, doe, ps_n, ds_n, rd_n, wr_n, drv;
  logic [7:0]  lo_p, hi_p;
  logic [15:0] exp_mem [logic [16:0]];  // Reference memory
  int          num_errors = 0, checked = 0;
  always #50 mclk_i = ~mclk_i;
  assign abus = (aoe & ao) | (~aoe & pad);        // Address pin levels
  assign dbus = doe ? dout : drv ? mdat : 16'hffff; // Pull-ups when free
  emb_port uut (.mclk_i, .srst_i, .req_i, .req_write_i, .req_prog_i,
    .req_addr_i, .req_wdata_i, .busy_o, .done_o, .rdata_o, .alt_sel_i,
    .alt_dir_i, .alt_out_i, .low_addr_alt_port_o(lo_p),
    .high_addr_alt_port_o(hi_p), .ext_addr_bus_i(abus), .ext_addr_bus_o(ao),
    .ext_addr_bus_oe_o(aoe), .ext_data_bus_i(dbus), .ext_data_bus_o(dout),
    .ext_data_bus_oe_o(doe), .program_space_select_n_o(ps_n),
    .data_space_select_n_o(ds_n), .read_strobe_n_o(rd_n),
    .write_strobe_n_o(wr_n));
  emb_sram u_mem (.mclk_i, .ps_n_i(ps_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .addr_i(abus), .data_i(dbus), .data_o(mdat), .drive_o(drv));
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One access, with a refused request in mid-cycle
  task automatic acc(input bit w, p, input logic [15:0] a, d);
    logic [15:0] e;
    int n = 0;
    while ((busy_o !== 1'b0 || done_o !== 1'b0) && n++ < 20) tick(1);
    {req_i, req_write_i, req_prog_i} = {1'b1, w, p};
    {req_addr_i, req_wdata_i} = {a, d};
    e = exp_mem.exists({p, a}) ? exp_mem[{p, a}] : 16'h0;
    if (w) exp_mem[{p, a}] = d;
    tick(1);
    chk("addr", abus, a);
    chk("sel", {ps_n, ds_n}, p ? 2'b01 : 2'b10);
    chk("data", dbus, w ? d : e);
    {req_i, req_addr_i} = {1'b1, ~a};
    tick(1);
    req_i = 0;
    n = 0;
    while (done_o !== 1'b1 && n++ < 10) tick(1);
    chk("done", done_o, 1);
    tick(1);
    if (!w) chk("rdata", rdata_o, e);
    tick(1);
    chk("idle", {busy_o, doe, ps_n & ds_n & rd_n & wr_n}, 3'b001);
  endtask
  initial begin
    void'($urandom(32'h7f4739a3));
    tick(16);
    srst_i = 0;
    tick(1);
    chk("rst", aoe, 16'hffff);
    repeat (40) acc($urandom_range(1), $urandom_range(1),
      16'($urandom) & 16'h8001, 16'($urandom));
    repeat (4) begin
      {alt_sel_i, alt_dir_i, alt_out_i, pad} = {$urandom, $urandom};
      tick(4);
      chk("oe", aoe, ~alt_sel_i | alt_dir_i);
      chk("port", {hi_p, lo_p} & alt_sel_i, alt_sel_i &
        ((alt_dir_i & alt_out_i) | (~alt_dir_i & pad)));
    end
    alt_sel_i = '0;
    tick(2);
    wrap_up;
  end
  initial begin
    #(2000 * 100);
    num_errors++;
    wrap_up;
  end
endmodule // tb_top
